// >>> src/modem_line_control_regs.sv
// Purpose: control and status byte logic of a line interface
// Assumes: strobes and data arrive async, synchronised here
// Notes: write taken on rising edge of write strobe; no register
//   address, one byte each way
`timescale 1ns/1ps
module modem_line_control_regs
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic out_band_energy_i,
  input wire logic in_band_energy_i,
  output logic monitor_audio_on_o,
  output logic hybrid_bypass_o,
  output logic line_tx_gate_o,
  output logic line_tx_pass_o,
  output logic [4:0] tone_code_o,
  output logic tone_active_o,
  output logic normal_power_flag_o,
  output logic [10:0] freq_lo_o,
  output logic [10:0] freq_hi_o
);
  // two-flop synchronisers for async pins
  logic [1:0] cs_n_sync;
  logic [1:0] rd_n_sync;
  logic [1:0] wr_n_sync;
  logic [1:0] obe_sync;
  logic [1:0] ibe_sync;
  logic [7:0] data_meta;
  logic [7:0] data_sync;
  logic wr_n_prev;
  logic [7:0] line_control_byte;
  wire logic wr_sel;
  wire logic wr_rise;
  wire logic rd_sel;
  wire logic [7:0] line_status_byte;
  wire logic [4:0] code_field;
  line_ctl_pkg::tone_mode_e tone_mode;
  wire logic [10:0] dec_lo;
  wire logic [10:0] dec_hi;
  wire logic next_tone_active;
  wire logic next_normal_power;
  wire logic next_tx_pass;

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cs_n_sync <= 2'h3;
      rd_n_sync <= 2'h3;
      wr_n_sync <= 2'h3;
      obe_sync <= 2'h0;
      ibe_sync <= 2'h0;
      data_meta <= 8'h00;
      data_sync <= 8'h00;
      wr_n_prev <= 1'b1;
    end
    else if (clk_en_i)
    begin
      cs_n_sync <= {cs_n_sync[0], cs_n_i};
      rd_n_sync <= {rd_n_sync[0], rd_n_i};
      wr_n_sync <= {wr_n_sync[0], wr_n_i};
      obe_sync <= {obe_sync[0], out_band_energy_i};
      ibe_sync <= {ibe_sync[0], in_band_energy_i};
      data_meta <= data_i;
      data_sync <= data_meta;
      wr_n_prev <= wr_n_sync[1] | cs_n_sync[1];
    end
  end

  // write completes when strobe pair releases
  assign wr_sel = ~wr_n_sync[1] & ~cs_n_sync[1];
  assign wr_rise = wr_n_prev == 1'b0 && !wr_sel;
  assign rd_sel = ~rd_n_sync[1] & ~cs_n_sync[1];

  // latch live whenever clock enabled, even in standby
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      line_control_byte <= line_ctl_pkg::CTL_RESET;
    else if (clk_en_i && wr_rise)
      line_control_byte <= data_sync;
  end

  assign code_field =
    line_control_byte[line_ctl_pkg::CTL_CODE_MSB:0];

  tone_code_decode u_decode
  (
    .code_i(code_field),
    .mode_o(tone_mode),
    .freq_lo_o(dec_lo),
    .freq_hi_o(dec_hi)
  );

  // tone only for single and dual codes
  assign next_tone_active = (tone_mode == line_ctl_pkg::TONE_SINGLE) ||
    (tone_mode == line_ctl_pkg::TONE_DUAL);
  // any code but 7 leaves standby
  assign next_normal_power =
    tone_mode != line_ctl_pkg::TONE_STANDBY;
  // transmit reaches line only in two-wire mode
  assign next_tx_pass = line_control_byte[line_ctl_pkg::CTL_TXG_BIT] &
    ~line_control_byte[line_ctl_pkg::CTL_HYB_BIT];

  assign line_status_byte = {
    monitor_audio_on_o,
    hybrid_bypass_o,
    line_tx_gate_o,
    obe_sync[1],
    ibe_sync[1],
    tone_active_o,
    normal_power_flag_o,
    1'b0
  };

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      monitor_audio_on_o <= 1'b0;
      hybrid_bypass_o <= 1'b0;
      line_tx_gate_o <= 1'b0;
      line_tx_pass_o <= 1'b0;
      tone_code_o <= 5'h00;
      tone_active_o <= 1'b0;
      normal_power_flag_o <= 1'b1;
      freq_lo_o <= 11'h000;
      freq_hi_o <= 11'h000;
    end
    else if (clk_en_i)
    begin
      monitor_audio_on_o <=
        line_control_byte[line_ctl_pkg::CTL_MON_BIT];
      hybrid_bypass_o <= line_control_byte[line_ctl_pkg::CTL_HYB_BIT];
      line_tx_gate_o <= line_control_byte[line_ctl_pkg::CTL_TXG_BIT];
      line_tx_pass_o <= next_tx_pass;
      tone_code_o <= code_field;
      tone_active_o <= next_tone_active;
      normal_power_flag_o <= next_normal_power;
      freq_lo_o <= dec_lo;
      freq_hi_o <= dec_hi;
    end
  end

  // read port drives bus while selected
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      data_o <= line_status_byte;
      data_oe_o <= rd_sel;
    end
  end
endmodule // modem_line_control_regs

// >>> src/line_ctl_pkg.sv
// Purpose: shared constants for the line control register block
// Assumes: 8-bit control byte, 7-bit status byte in upper bits
// Notes: tone codes and field positions
package line_ctl_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned FREQ_W = 11;
  // control byte fields
  localparam int unsigned CTL_MON_BIT = 7;
  localparam int unsigned CTL_HYB_BIT = 6;
  localparam int unsigned CTL_TXG_BIT = 5;
  localparam int unsigned CTL_CODE_MSB = 4;
  // status byte fields
  localparam int unsigned STS_MON_BIT = 7;
  localparam int unsigned STS_HYB_BIT = 6;
  localparam int unsigned STS_TXG_BIT = 5;
  localparam int unsigned STS_OBE_BIT = 4;
  localparam int unsigned STS_IBE_BIT = 3;
  localparam int unsigned STS_TONE_BIT = 2;
  localparam int unsigned STS_PWR_BIT = 1;
  localparam int unsigned STS_UNUSED_BIT = 0;
  // reset values: everything off, normal power
  localparam logic [7:0] CTL_RESET = 8'h00;
  // tone codes
  localparam logic [4:0] CODE_TERMINATE = 5'h00;
  localparam logic [4:0] CODE_STANDBY = 5'h07;
  localparam logic [4:0] CODE_SINGLE_LO = 5'h08;
  localparam logic [4:0] CODE_DTMF_LO = 5'h10;
  // tone frequencies in Hz
  localparam logic [10:0] F_697 = 11'h2B9;
  localparam logic [10:0] F_770 = 11'h302;
  localparam logic [10:0] F_852 = 11'h354;
  localparam logic [10:0] F_941 = 11'h3AD;
  localparam logic [10:0] F_1209 = 11'h4B9;
  localparam logic [10:0] F_1336 = 11'h538;
  localparam logic [10:0] F_1477 = 11'h5C5;
  localparam logic [10:0] F_1633 = 11'h661;
  localparam logic [10:0] F_NONE = 11'h000;
  typedef enum logic [1:0] {
    TONE_IDLE = 2'b00,
    TONE_SINGLE = 2'b01,
    TONE_DUAL = 2'b10,
    TONE_STANDBY = 2'b11
  } tone_mode_e;
endpackage

// >>> src/tone_code_decode.sv
// Purpose: decode a 5-bit tone code into mode and frequency pair
// Assumes: purely combinational, code already latched
// Notes: reserved codes decode as idle
`timescale 1ns/1ps
module tone_code_decode
(
  input wire logic [4:0] code_i,
  output line_ctl_pkg::tone_mode_e mode_o,
  output logic [10:0] freq_lo_o,
  output logic [10:0] freq_hi_o
);
  wire logic [2:0] low_sel;
  wire logic [2:0] row_sel;
  wire logic [1:0] col_sel;
  wire logic is_single;
  wire logic is_dual;
  logic [10:0] row_freq;
  logic [10:0] col_freq;
  logic [10:0] single_freq;
  logic [2:0] dtmf_row;
  logic [1:0] dtmf_col;

  assign low_sel = code_i[2:0];
  assign is_single = (code_i[4:3] == 2'b01);
  assign is_dual = code_i[4];
  assign row_sel = dtmf_row;
  assign col_sel = dtmf_col;

  // single tone order 697..1633
  always_comb
  begin
    unique case (low_sel)
      3'h0: single_freq = line_ctl_pkg::F_697;
      3'h1: single_freq = line_ctl_pkg::F_770;
      3'h2: single_freq = line_ctl_pkg::F_852;
      3'h3: single_freq = line_ctl_pkg::F_941;
      3'h4: single_freq = line_ctl_pkg::F_1209;
      3'h5: single_freq = line_ctl_pkg::F_1336;
      3'h6: single_freq = line_ctl_pkg::F_1477;
      3'h7: single_freq = line_ctl_pkg::F_1633;
    endcase
  end

  // dtmf: digit 0, 1-9, star, pound, then 1633 column
  always_comb
  begin
    unique case (code_i[3:0])
      4'h0: begin dtmf_row = 3'h3; dtmf_col = 2'h1; end
      4'h1: begin dtmf_row = 3'h0; dtmf_col = 2'h0; end
      4'h2: begin dtmf_row = 3'h0; dtmf_col = 2'h1; end
      4'h3: begin dtmf_row = 3'h0; dtmf_col = 2'h2; end
      4'h4: begin dtmf_row = 3'h1; dtmf_col = 2'h0; end
      4'h5: begin dtmf_row = 3'h1; dtmf_col = 2'h1; end
      4'h6: begin dtmf_row = 3'h1; dtmf_col = 2'h2; end
      4'h7: begin dtmf_row = 3'h2; dtmf_col = 2'h0; end
      4'h8: begin dtmf_row = 3'h2; dtmf_col = 2'h1; end
      4'h9: begin dtmf_row = 3'h2; dtmf_col = 2'h2; end
      4'hA: begin dtmf_row = 3'h3; dtmf_col = 2'h0; end
      4'hB: begin dtmf_row = 3'h3; dtmf_col = 2'h2; end
      4'hC: begin dtmf_row = 3'h0; dtmf_col = 2'h3; end
      4'hD: begin dtmf_row = 3'h1; dtmf_col = 2'h3; end
      4'hE: begin dtmf_row = 3'h2; dtmf_col = 2'h3; end
      4'hF: begin dtmf_row = 3'h3; dtmf_col = 2'h3; end
    endcase
  end

  always_comb
  begin
    unique case (row_sel[1:0])
      2'h0: row_freq = line_ctl_pkg::F_697;
      2'h1: row_freq = line_ctl_pkg::F_770;
      2'h2: row_freq = line_ctl_pkg::F_852;
      2'h3: row_freq = line_ctl_pkg::F_941;
    endcase
  end

  always_comb
  begin
    unique case (col_sel)
      2'h0: col_freq = line_ctl_pkg::F_1209;
      2'h1: col_freq = line_ctl_pkg::F_1336;
      2'h2: col_freq = line_ctl_pkg::F_1477;
      2'h3: col_freq = line_ctl_pkg::F_1633;
    endcase
  end

  assign mode_o = is_dual ? line_ctl_pkg::TONE_DUAL :
    is_single ? line_ctl_pkg::TONE_SINGLE :
    (code_i == line_ctl_pkg::CODE_STANDBY) ? line_ctl_pkg::TONE_STANDBY :
    line_ctl_pkg::TONE_IDLE;
  assign freq_lo_o = is_dual ? row_freq :
    (is_single ? single_freq : line_ctl_pkg::F_NONE);
  assign freq_hi_o = is_dual ? col_freq : line_ctl_pkg::F_NONE;
endmodule // tone_code_decode

// >>> dv/line_ctl_chk.sv
// Purpose: port checks for line control regs
// Assumes: one clock, async active-low reset
// Notes: status checked while driven
`timescale 1ns/1ps
module line_ctl_chk
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  input wire logic monitor_audio_on_o,
  input wire logic hybrid_bypass_o,
  input wire logic line_tx_gate_o,
  input wire logic line_tx_pass_o,
  input wire logic [4:0] tone_code_o,
  input wire logic tone_active_o,
  input wire logic normal_power_flag_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  // frozen clock leaves strobes unseen
  default disable iff (!resetn_i || !clk_en_i);
  sts_echo_a: assert property (data_oe_o |->
    data_o[7:5] == {monitor_audio_on_o, hybrid_bypass_o, line_tx_gate_o})
    else $error("status echo wrong");
  sts_flags_a: assert property (data_oe_o |->
    data_o[2:1] == {tone_active_o, normal_power_flag_o})
    else $error("status flags wrong");
  sts_unused_a: assert property (data_oe_o |-> !data_o[0])
    else $error("status bit 0 set");
  tone_flag_a: assert property ($stable(tone_code_o) |->
    tone_active_o == (tone_code_o[4:3] != 2'b00))
    else $error("tone flag wrong");
  power_flag_a: assert property ($stable(tone_code_o) |->
    normal_power_flag_o == (tone_code_o != 5'h07))
    else $error("power flag wrong");
  tx_pass_a: assert property ($stable({line_tx_gate_o, hybrid_bypass_o})
    |-> line_tx_pass_o == (line_tx_gate_o && !hybrid_bypass_o))
    else $error("transmit pass wrong");
  write_load_a: assert property ($rose(wr_n_i) |-> ##[2:6]
    {monitor_audio_on_o, hybrid_bypass_o, line_tx_gate_o, tone_code_o}
    == data_i) else $error("control byte not loaded");
  read_answer_a: assert property ($fell(rd_n_i) |-> ##[2:5] data_oe_o)
    else $error("read not answered");
endmodule // line_ctl_chk
bind modem_line_control_regs line_ctl_chk chk_u (.core_clk_i(core_clk_i),
  .resetn_i(resetn_i), .clk_en_i(clk_en_i), .rd_n_i(rd_n_i),
  .wr_n_i(wr_n_i), .data_i(data_i),
  .data_o(data_o), .data_oe_o(data_oe_o),
  .monitor_audio_on_o(monitor_audio_on_o), .hybrid_bypass_o(hybrid_bypass_o),
  .line_tx_gate_o(line_tx_gate_o), .line_tx_pass_o(line_tx_pass_o),
  .tone_code_o(tone_code_o), .tone_active_o(tone_active_o),
  .normal_power_flag_o(normal_power_flag_o));

// >>> dv/host_bus_model.sv
// Purpose: microprocessor side of the register bus
// Assumes: callers start tasks at a falling edge
// Notes: released data shows the inverse of the last byte
`timescale 1ns/1ps
module host_bus_model
(
  input wire logic core_clk_i,
  input wire logic data_oe_i,
  input wire logic [7:0] bus_i,
  output logic cs_n_o = 1'b1,
  output logic rd_n_o = 1'b1,
  output logic wr_n_o = 1'b1,
  output logic [7:0] data_o = 8'h00
);
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic write_byte(input logic [7:0] d);
    cs_n_o = 1'b0;
    wr_n_o = 1'b0;
    data_o = d;
    wait_n(4);
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    wait_n(7);
    data_o = ~d;
    wait_n(1);
  endtask
  task automatic read_byte(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    for (int i = 0; i < 10 && !ok; i++)
    begin
      wait_n(1);
      ok = (data_oe_i === 1'b1);
    end
    d = bus_i;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wait_n(6);
  endtask
endmodule // host_bus_model

// >>> dv/test_modem_line_control_regs.sv
// Purpose: directed bench for the line control registers
// Assumes: host model drives the bus at falling edges
// Notes: reserved tone codes are never written
`timescale 1ns/1ps
module test_modem_line_control_regs;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cs_n, rd_n, wr_n, oe, mon, hyb, txg, pass, act, pwr;
  logic en = 1'b1;
  logic out_band_energy = 1'b0;
  logic in_band_energy = 1'b0;
  logic [7:0] hdata, rdata, bus;
  logic [4:0] code;
  logic [10:0] flo, fhi;
  int fail_count = 0;
  int checks = 0;
  logic [10:0] ft [8] = '{11'h2B9, 11'h302, 11'h354, 11'h3AD,
    11'h4B9, 11'h538, 11'h5C5, 11'h661};
  int rw [16] = '{3, 0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 0, 1, 2, 3};
  int cl [16] = '{5, 4, 5, 6, 4, 5, 6, 4, 5, 6, 4, 6, 7, 7, 7, 7};
  assign bus = oe ? rdata : hdata;
  modem_line_control_regs dut_u (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .clk_en_i(en), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .data_i(bus), .data_o(rdata), .data_oe_o(oe),
    .out_band_energy_i(out_band_energy), .in_band_energy_i(in_band_energy),
    .monitor_audio_on_o(mon), .hybrid_bypass_o(hyb), .line_tx_gate_o(txg),
    .line_tx_pass_o(pass), .tone_code_o(code), .tone_active_o(act),
    .normal_power_flag_o(pwr), .freq_lo_o(flo), .freq_hi_o(fhi));
  host_bus_model host_u (.core_clk_i(core_clk_i), .data_oe_i(oe),
    .bus_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .data_o(hdata));
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [10:0] e, g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic rd_chk(input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host_u.read_byte(d, ok);
    chk("status", {3'h0, e}, {3'h0, d});
    if (!ok)
    begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic wr_chk(input logic [7:0] d, input logic [3:0] e);
    host_u.write_byte(d);
    chk("bits", {7'h00, e}, {7'h00, mon, hyb, txg, pass});
  endtask
  task automatic t_bits();
    rd_chk(8'h02);
    wr_chk(8'hE0, 4'hE);
    rd_chk(8'hE2);
    wr_chk(8'hA0, 4'hB);
    rd_chk(8'hA2);
    wr_chk(8'h40, 4'h4);
    rd_chk(8'h42);
    $display("test bits done");
  endtask
  task automatic t_tones();
    logic [10:0] el, eh;
    for (int i = 0; i < 32; i++)
    begin
      if (i inside {[1:6]})
        continue;
      el = (i >= 16) ? ft[rw[i-16]] : (i >= 8) ? ft[i-8] : 11'h000;
      eh = (i >= 16) ? ft[cl[i-16]] : 11'h000;
      host_u.write_byte({3'h0, i[4:0]});
      chk("code", {6'h00, i[4:0]}, {6'h00, code});
      chk("freq lo", el, flo);
      chk("freq hi", eh, fhi);
      rd_chk({5'h00, i >= 8, i != 7, 1'b0});
    end
    host_u.write_byte(8'h07);
    rd_chk(8'h00);
    host_u.write_byte(8'h00);
    rd_chk(8'h02);
    $display("test tones done");
  endtask
  task automatic t_energy();
    out_band_energy = 1'b1;
    host_u.wait_n(4);
    rd_chk(8'h12);
    out_band_energy = 1'b0;
    in_band_energy = 1'b1;
    host_u.wait_n(4);
    rd_chk(8'h0A);
    $display("test energy done");
  endtask
  task automatic t_enable();
    in_band_energy = 1'b0;
    en = 1'b0;
    host_u.write_byte(8'h80);
    chk("frozen", 11'h000, {10'h000, mon});
    en = 1'b1;
    host_u.wait_n(4);
    rd_chk(8'h02);
    wr_chk(8'hE8, 4'hE);
    chk("tone", 11'h003, {9'h000, act, pwr});
    resetn_i = 1'b0;
    host_u.wait_n(2);
    chk("reset", 11'h001, {6'h00, mon, hyb, txg, act, pwr});
    chk("reset lo", 11'h000, flo);
    resetn_i = 1'b1;
    host_u.wait_n(2);
    rd_chk(8'h02);
    $display("test enable done");
  endtask
  initial
  begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    repeat (12) @(negedge core_clk_i);
    resetn_i = 1'b1;
    host_u.wait_n(2);
    t_bits();
    t_tones();
    t_energy();
    t_enable();
    complete_run();
  end
  initial
  begin
    #2000000;
    fail_count++;
    complete_run();
  end
endmodule // test_modem_line_control_regs
